// >>> rtl/timer_channel_stop_io_control.v
// Stop trigger, input select, output enable and pin buffer registers of a 4-channel timer
`timescale 1ns/10ps
`default_nettype none
`include "timer_ctl_regs.vh"
// Functional notes
// [R1] Writing 1 to a stop bit clears the run flag; 0 does nothing.
// [R2] Stop bits never hold; they clear once the run flag is zero.
// [R3] Bit 11 stops channel 3 upper half, bit 9 channel 1 upper half.
// [R4] Stop bits 3..0 serve channels 3..0, lower half only in 8-bit mode.
// [R5] Reading the stop register always returns zero.
// [R6] Software writes zero to the unused stop register bits.
// [R7] Stop register takes word writes; low byte also bit and byte writes.
// [R8] Reset clears stop, enable, buffer to 0000H and input select to 00H.
// [R9] Input select bit 4 picks channel 0 pin or event link signal.
// [R10] Channel 1 codes: 000/010 pin, 001 event link, 100 slow oscillator.
// [R11] Software writes only defined channel 1 codes, with byte accesses.
// [R12] Software turns filter off and picks CPU clock when event link chosen.
// [R13] Output enable 0: timer cannot change the bit; software writes reach pin.
// [R14] Output enable 1: timer drives the bit; software writes ignored.
// [R15] Bits 3..0 serve channels 3..0; buffer bits drive pins directly.
// [R16] Software clears buffer bit before a shared pin becomes a port.
// [R17] Software keeps bits 15..4 of enable and buffer at zero.
// [R18] Buffer takes word and low byte writes, no bit writes; enable also bit writes.
// [R19] Launch trigger sets the run flag; the stop trigger clears it.
module timer_channel_stop_io_control #(
   parameter CH = 4
) (
   input  wire                ref_clk,
   input  wire                resetn,
   input  wire [`ADDR_W-1:0]  bus_addr,
   input  wire                bus_wr,
   input  wire                bus_rd,
   input  wire [1:0]          bus_size,
   input  wire [3:0]          bus_bit_sel,
   input  wire [15:0]         bus_wdata,
   output reg  [15:0]         bus_rdata,
   input  wire [15:0]         channel_launch_trigger,
   input  wire [CH-1:0]       timer_wave_set,
   input  wire [CH-1:0]       timer_wave_value,
   input  wire                ch0_pin_in,
   input  wire                ch1_pin_in,
   input  wire                event_link_in,
   input  wire                slow_internal_osc_clock,
   output wire [15:0]         run_status_register,
   output wire [5:0]          halt_pending,
   output wire                ch0_timer_input,
   output wire                ch1_timer_input,
   output wire [CH-1:0]       timer_out_pin
);
   // Overview of the slice
   // Four registers sit on the byte-addressed register bus:
   //   input select   8 bits,  byte writes only, bits 4 and 2..0 stored
   //   halt trigger  16 bits,  write only, always reads as zero
   //   pin buffer    16 bits,  bits 3..0 stored, drives the timer pins
   //   output enable 16 bits,  bits 3..0 stored, hands a bit to the timer
   // Access sizes on the bus:
   //   bit  : touches one bit of the low byte, picked by bus_bit_sel
   //   byte : touches bits 7..0 only
   //   word : touches all sixteen bits
   // Run flags:
   //   Six flags, channels 3..0 plus the upper halves of channels 1 and 3.
   //   A launch bit sets a flag; a halt bit clears it on the same edge.
   //   When both arrive together the halt wins, so software never sees
   //   a channel that it has just stopped come back to life.
   // Halt trigger bits:
   //   Each written one becomes a pending bit for one cycle and falls away
   //   once its run flag reads zero, so nothing is ever held.
   //   The pending bit also keeps the flag low for that cycle, which means
   //   a launch in the cycle right after a halt is lost; the timer core
   //   must space a restart by at least one cycle.
   // Pin buffer:
   //   With the enable bit low, only software writes reach a buffer bit.
   //   With the enable bit high, only the timer core reaches it, through
   //   timer_wave_set and timer_wave_value; software writes are dropped.
   //   Bit writes to the buffer are not decoded at all.
   // Input select:
   //   Channel 0 takes its pin or the event link line.
   //   Channel 1 takes its pin, the event link line or the slow oscillator.
   //   Codes that are not defined fall back to the pin, so a bad code
   //   never leaves the channel without an input.
   // Hazards for users:
   //   The input multiplexers are combinational; a source switch can make
   //   a short glitch that the timer core must filter or ignore.
   //   Read data is registered and stands until the next read strobe.
   reg  [7:0]    input_sel_q;
   reg  [CH-1:0] out_enable_q;
   reg  [CH-1:0] pin_buffer_q;
   reg  [CH-1:0] run_low_q;
   reg           upper_run_ch1_q;
   reg           upper_run_ch3_q;
   reg  [15:0]   wr_data;
   reg  [15:0]   wr_mask;
   wire          hit_halt;
   wire          hit_buffer;
   wire          hit_enable;
   wire          hit_select;
   wire [5:0]    halt_req;
   wire [5:0]    launch_req;
   wire [5:0]    run_flags;
   reg  [2:0]    ch1_code;
   reg           ch1_mux;
   reg  [15:0]   rdata_d;
   integer       k;
   genvar        ch;

   // Address decode
   assign hit_halt   = bus_wr && (bus_addr == `ADDR_HALT_TRIGGER);
   assign hit_buffer = bus_wr && (bus_addr == `ADDR_PIN_BUFFER);
   assign hit_enable = bus_wr && (bus_addr == `ADDR_OUTPUT_ENABLE);
   assign hit_select = bus_wr && (bus_addr == `ADDR_INPUT_SELECT) && (bus_size == `ACC_BYTE); // [R11]

   // Write lane mask by access size: bit, low byte or whole word
   always @*
   begin
      wr_mask = 16'h0000;
      wr_data = bus_wdata;
      case (bus_size)
         `ACC_BIT:
         begin
            for (k = 0; k < 8; k = k + 1)
               wr_mask[k] = (bus_bit_sel[2:0] == k[2:0]) && !bus_bit_sel[3];
         end
         `ACC_BYTE:
            wr_mask = 16'h00FF;
         `ACC_WORD:
            wr_mask = 16'hFFFF;
         default:
            wr_mask = 16'h0000;
      endcase
   end

   // Stop requests, only on masked lanes where a one is written
   wire [15:0] halt_bits = hit_halt ? (wr_data & wr_mask) : 16'h0000; // [R7]
   assign halt_req = {halt_bits[`BIT_UPPER_HALT_CH3], halt_bits[`BIT_UPPER_HALT_CH1],
                      halt_bits[CH-1:0]};                               // [R1] [R3] [R4]
   assign launch_req = {channel_launch_trigger[`BIT_UPPER_HALT_CH3],
                        channel_launch_trigger[`BIT_UPPER_HALT_CH1],
                        channel_launch_trigger[CH-1:0]};
   assign run_flags  = {upper_run_ch3_q, upper_run_ch1_q, run_low_q};

   // Trigger bits that fall away once the run flag is clear
   halt_pulse_bank #(
      .N (6)
   ) u_halt (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .set_req   (halt_req),
      .run_flags (run_flags),
      .pending   (halt_pending)
   );

   // Run flags: launch sets, stop request or pending trigger clears
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         run_low_q       <= {CH{1'b0}};
         upper_run_ch1_q <= 1'b0;
         upper_run_ch3_q <= 1'b0;
      end
      else
      begin
         run_low_q <= (run_low_q | launch_req[CH-1:0])
                      & ~(halt_req[CH-1:0] | halt_pending[CH-1:0]);          // [R1] [R19]
         upper_run_ch1_q <= (upper_run_ch1_q | launch_req[4])
                            & ~(halt_req[4] | halt_pending[4]);               // [R3]
         upper_run_ch3_q <= (upper_run_ch3_q | launch_req[5])
                            & ~(halt_req[5] | halt_pending[5]);               // [R3]
      end
   end

   assign run_status_register = {4'h0, upper_run_ch3_q, 1'b0, upper_run_ch1_q, 5'h00,
                                 run_low_q};

   // Configuration registers
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         input_sel_q  <= `RST_INPUT_SELECT;          // [R8]
         out_enable_q <= {CH{1'b0}};                 // [R8]
      end
      else
      begin
         if (hit_select)
            input_sel_q <= bus_wdata[7:0] & `INPUT_SELECT_MASK;
         if (hit_enable)
            out_enable_q <= (out_enable_q & ~wr_mask[CH-1:0])
                            | (wr_data[CH-1:0] & wr_mask[CH-1:0]);   // [R18]
      end
   end

   // Pin buffer, one flop per channel: the timer owns the bit while enabled
   generate
      for (ch = 0; ch < CH; ch = ch + 1)
      begin : g_pin
         wire sw_write = hit_buffer && (bus_size != `ACC_BIT) && !out_enable_q[ch];
         wire hw_write = out_enable_q[ch] && timer_wave_set[ch];
         always @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
               pin_buffer_q[ch] <= 1'b0;                     // [R8]
            else if (hw_write)
               pin_buffer_q[ch] <= timer_wave_value[ch];     // [R14]
            else if (sw_write)
               pin_buffer_q[ch] <= wr_data[ch];              // [R13] [R18]
         end
      end
   endgenerate

   // Pins follow the buffer directly
   assign timer_out_pin = pin_buffer_q;                            // [R15]

   // Input source selection
   assign ch0_timer_input = input_sel_q[`BIT_CH0_SOURCE] ? event_link_in : ch0_pin_in; // [R9]
   always @*
   begin
      ch1_code = input_sel_q[2:0];
      case (ch1_code)
         `CH1_SRC_EVENT:    ch1_mux = event_link_in;               // [R10]
         `CH1_SRC_SLOW_OSC: ch1_mux = slow_internal_osc_clock;     // [R10]
         `CH1_SRC_PIN_A:    ch1_mux = ch1_pin_in;
         `CH1_SRC_PIN_B:    ch1_mux = ch1_pin_in;
         default:           ch1_mux = ch1_pin_in;
      endcase
   end
   assign ch1_timer_input = ch1_mux;

   // Read multiplexer; stop register and unmapped addresses read zero
   always @*
   begin
      rdata_d = 16'h0000;
      case (bus_addr)
         `ADDR_INPUT_SELECT:  rdata_d = {8'h00, input_sel_q};
         `ADDR_HALT_TRIGGER:  rdata_d = 16'h0000;                       // [R5]
         `ADDR_PIN_BUFFER:    rdata_d = {{(16-CH){1'b0}}, pin_buffer_q};
         `ADDR_OUTPUT_ENABLE: rdata_d = {{(16-CH){1'b0}}, out_enable_q};
         default:             rdata_d = 16'h0000;
      endcase
   end

   // Read data register, stands until the next read strobe
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         bus_rdata <= 16'h0000;
      else if (bus_rd)
         bus_rdata <= rdata_d;
   end
endmodule // timer_channel_stop_io_control
`default_nettype wire

// >>> rtl/timer_ctl_regs.vh
// Register addresses, field positions and reset values of the timer control slice
`ifndef TIMER_CTL_REGS_VH
`define TIMER_CTL_REGS_VH
`define ADDR_W               20
`define ADDR_INPUT_SELECT    20'hF0074
`define ADDR_HALT_TRIGGER    20'hF01B4
`define ADDR_PIN_BUFFER      20'hF01B8
`define ADDR_OUTPUT_ENABLE   20'hF01BA
`define RST_INPUT_SELECT     8'h00
`define RST_HALF_WORD        16'h0000
`define BIT_CH0_SOURCE       4
`define BIT_UPPER_HALT_CH1   9
`define BIT_UPPER_HALT_CH3   11
`define CH1_SRC_PIN_A        3'h0
`define CH1_SRC_EVENT        3'h1
`define CH1_SRC_PIN_B        3'h2
`define CH1_SRC_SLOW_OSC     3'h4
`define INPUT_SELECT_MASK    8'h17
`define ACC_BIT              2'h0
`define ACC_BYTE             2'h1
`define ACC_WORD             2'h2
`endif

// >>> rtl/halt_pulse_bank.v
// Self-clearing trigger bits, one per run flag
`timescale 1ns/10ps
`default_nettype none
module halt_pulse_bank #(
   parameter N = 6
) (
   input  wire         ref_clk,
   input  wire         resetn,
   input  wire [N-1:0] set_req,
   input  wire [N-1:0] run_flags,
   output wire [N-1:0] pending
);
   reg [N-1:0] trig_q;
   genvar i;
   // Each bit holds until its run flag reads zero; a new set wins over the self clear
   generate
      for (i = 0; i < N; i = i + 1)
      begin : g_bit
         always @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
               trig_q[i] <= 1'b0;
            else if (set_req[i])
               trig_q[i] <= 1'b1;
            else if (!run_flags[i])
               trig_q[i] <= 1'b0;   // [R2]
         end
      end
   endgenerate
   assign pending = trig_q;
endmodule // halt_pulse_bank
`default_nettype wire

// >>> bench/timer_ctl_checker.sv
// Port assertions for the timer control slice
`timescale 1ns/10ps
`default_nettype none
`include "timer_ctl_regs.vh"
module timer_ctl_checker #(
   parameter CH = 4
) (
   input wire logic               ref_clk,
   input wire logic               resetn,
   input wire logic [`ADDR_W-1:0] bus_addr,
   input wire logic               bus_wr,
   input wire logic               bus_rd,
   input wire logic [1:0]         bus_size,
   input wire logic [15:0]        bus_wdata,
   input wire logic [15:0]        bus_rdata,
   input wire logic [15:0]        channel_launch_trigger,
   input wire logic [CH-1:0]      timer_wave_set,
   input wire logic [15:0]        run_status_register,
   input wire logic [5:0]         halt_pending,
   input wire logic [CH-1:0]      timer_out_pin
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Word write to the stop register
   wire hw = bus_wr && bus_addr == `ADDR_HALT_TRIGGER && bus_size == `ACC_WORD;
   property p_halt0; hw && bus_wdata[0] |=> !run_status_register[0]; endproperty
   a_halt0: assert property (p_halt0) else $error("stop bit 0 left run flag");
   property p_up9; hw && bus_wdata[9] |=> !run_status_register[9]; endproperty
   a_up9: assert property (p_up9) else $error("stop bit 9 left upper run flag");
   property p_zero;
      hw && bus_wdata == 16'h0000 && channel_launch_trigger == 16'h0000
         |=> $stable(run_status_register);
   endproperty
   a_zero: assert property (p_zero) else $error("zero stop write changed run flags");
   property p_self;
      halt_pending[5] && !run_status_register[11] && !bus_wr |=> !halt_pending[5];
   endproperty
   a_self: assert property (p_self) else $error("stop bit held a value");
   property p_rd; bus_rd && bus_addr == `ADDR_HALT_TRIGGER |=> bus_rdata == 16'h0000; endproperty
   a_rd: assert property (p_rd) else $error("stop register read not zero");
   property p_run; channel_launch_trigger[2] && !bus_wr |=> run_status_register[2]; endproperty
   a_run: assert property (p_run) else $error("launch did not set run flag");
   property p_hold; !bus_wr && timer_wave_set == 0 |=> $stable(timer_out_pin); endproperty
   a_hold: assert property (p_hold) else $error("pin moved with no cause");
   property p_bitbuf;
      bus_wr && bus_addr == `ADDR_PIN_BUFFER && bus_size == `ACC_BIT && timer_wave_set == 0
         |=> $stable(timer_out_pin);
   endproperty
   a_bitbuf: assert property (p_bitbuf) else $error("bit write changed buffer");
   property p_rst; $rose(resetn) |-> run_status_register == 0 && timer_out_pin == 0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule // timer_ctl_checker
bind timer_channel_stop_io_control timer_ctl_checker #(.CH(CH)) timer_ctl_checker_inst (
   .ref_clk, .resetn, .bus_addr, .bus_wr, .bus_rd, .bus_size, .bus_wdata, .bus_rdata,
   .channel_launch_trigger, .timer_wave_set, .run_status_register, .halt_pending,
   .timer_out_pin);
`default_nettype wire

// >>> bench/pin_partner.sv
// Far-side pin model: timer input pins, event line and slow clock
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   input  wire logic       ref_clk,
   input  wire logic [3:0] timer_out_pin,
   output wire logic [3:0] pins
);
   // Each line runs its own pattern so a wrong source choice shows
   logic [3:0] cnt_q = 4'h0;
   always @(negedge ref_clk) cnt_q <= cnt_q + 4'h1;
   assign pins = cnt_q ^ {2'h0, timer_out_pin[1:0]};
endmodule // pin_partner
`default_nettype wire

// >>> bench/timer_channel_stop_io_control_tb_top.sv
// Self-checking bench for the timer control slice
`timescale 1ns/10ps
`default_nettype none
`include "timer_ctl_regs.vh"
module timer_channel_stop_io_control_tb_top;
   logic ref_clk = 1'b0, resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
   logic [19:0] bus_addr = 20'h00000;
   logic [1:0]  bus_size = 2'h2;
   logic [3:0]  bus_bit_sel = 4'h0, wset = 4'h0, wval = 4'h0, timer_out_pin, pins;
   logic [15:0] bus_wdata = 16'h0000, bus_rdata, channel_launch_trigger = 16'h0000;
   logic [15:0] run_status_register;
   logic [5:0]  halt_pending;
   logic        ch0_timer_input, ch1_timer_input;
   int          fails = 0, num_checks = 0, cyc = 0;
   timer_channel_stop_io_control timer_channel_stop_io_control_inst (.ref_clk, .resetn,
      .bus_addr, .bus_wr, .bus_rd, .bus_size, .bus_bit_sel, .bus_wdata, .bus_rdata,
      .channel_launch_trigger, .timer_wave_set(wset), .timer_wave_value(wval),
      .ch0_pin_in(pins[0]), .ch1_pin_in(pins[1]), .event_link_in(pins[2]),
      .slow_internal_osc_clock(pins[3]), .run_status_register, .halt_pending,
      .ch0_timer_input, .ch1_timer_input, .timer_out_pin);
   pin_partner pin_partner_inst (.ref_clk, .timer_out_pin, .pins);
   initial forever #25 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [19:0] a, input logic [1:0] s, input logic [15:0] d,
                     input logic [3:0] b);
      @(negedge ref_clk);
      bus_addr = a;
      bus_size = s;
      bus_wdata = d;
      bus_bit_sel = b;
      bus_wr = 1'b1;
      @(negedge ref_clk);
      bus_wr = 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, output logic [15:0] q);
      @(negedge ref_clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge ref_clk);
      bus_rd = 1'b0;
      q = bus_rdata;
   endtask
   // Expected channel 1 source for a select code
   function automatic logic src1(input logic [2:0] c, input logic [3:0] p);
      return (c == 3'h1) ? p[2] : (c == 3'h4) ? p[3] : p[1];
   endfunction
   initial
   begin
      logic [15:0] q, e, r;
      logic [19:0] am[4] = '{20'hF0074, 20'hF01B4, 20'hF01B8, 20'hF01BA};
      int bl[6] = '{0, 1, 2, 3, 9, 11};
      logic [2:0] cd[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
      q = $urandom(80818);
      repeat (8) @(negedge ref_clk);
      resetn = 1'b1;
      foreach (am[k]) rd(am[k], q);
      foreach (am[k]) chk(q & 16'h0000, 16'h0000);
      foreach (am[k])
      begin
         rd(am[k], q);
         chk(q, 16'h0000);
      end
      $display("test reset done");
      channel_launch_trigger = 16'h0A0F;
      @(negedge ref_clk);
      channel_launch_trigger = 16'h0000;
      e = 16'h0A0F;
      chk(run_status_register, e);
      wr(`ADDR_HALT_TRIGGER, `ACC_WORD, 16'h0000, 4'h0);
      chk(run_status_register, e);
      foreach (bl[k])
      begin
         wr(`ADDR_HALT_TRIGGER, `ACC_WORD, 16'h0001 << bl[k], 4'h0);
         e = e & ~(16'h0001 << bl[k]);
         chk(run_status_register, e);
         @(negedge ref_clk);
         chk({10'h000, halt_pending}, 16'h0000);
      end
      channel_launch_trigger = 16'h000F;
      @(negedge ref_clk);
      channel_launch_trigger = 16'h0000;
      wr(`ADDR_HALT_TRIGGER, `ACC_BYTE, 16'h0005, 4'h0);
      wr(`ADDR_HALT_TRIGGER, `ACC_BIT, 16'hFFFF, 4'h3);
      chk(run_status_register, 16'h0002);
      rd(`ADDR_HALT_TRIGGER, q);
      chk(q, 16'h0000);
      $display("test stop trigger done");
      foreach (cd[k])
      begin
         r = {11'h000, 1'($urandom % 2), 1'b0, cd[k]};
         wr(`ADDR_INPUT_SELECT, `ACC_BYTE, r, 4'h0);
         @(posedge ref_clk);
         #1 chk({ch1_timer_input, ch0_timer_input},
                {src1(cd[k], pins), r[4] ? pins[2] : pins[0]});
         rd(`ADDR_INPUT_SELECT, q);
         chk(q, r);
      end
      $display("test input select done");
      repeat (3)
      begin
         r = 16'($urandom % 16);
         wr(`ADDR_PIN_BUFFER, `ACC_WORD, r, 4'h0);
         chk({12'h000, timer_out_pin}, r);
      end
      wr(`ADDR_OUTPUT_ENABLE, `ACC_BIT, 16'hFFFF, 4'h0);
      wr(`ADDR_PIN_BUFFER, `ACC_BYTE, r ^ 16'h000F, 4'h0);
      e = {12'h000, ~r[3:1], r[0]};
      chk({12'h000, timer_out_pin}, e);
      wr(`ADDR_PIN_BUFFER, `ACC_BIT, 16'hFFFF, 4'h1);
      chk({12'h000, timer_out_pin}, e);
      wset = 4'h1;
      wval = {3'h0, ~r[0]};
      @(negedge ref_clk);
      wset = 4'h0;
      chk({12'h000, timer_out_pin}, e ^ 16'h0001);
      rd(`ADDR_OUTPUT_ENABLE, q);
      chk(q, 16'h0001);
      wr(`ADDR_OUTPUT_ENABLE, `ACC_WORD, 16'h0000, 4'h0);
      wr(`ADDR_PIN_BUFFER, `ACC_WORD, 16'h0000, 4'h0);
      chk({12'h000, timer_out_pin}, 16'h0000);
      $display("test output done");
      tally_and_finish();
   end
endmodule // timer_channel_stop_io_control_tb_top
`default_nettype wire
